//--- rtl/dwu_cfg.svh
`ifndef DWU_CFG_SVH
`define DWU_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define DWU_OFF_MASTER 8'h00
`define DWU_OFF_ACTIVE 8'h04
`define DWU_OFF_MEMMAP 8'h08
`define DWU_OFF_STATUS 8'h0c
`define DWU_WIN_BASE_BIT 7
`define DWU_WF_START 5'h00
`define DWU_WF_PITCH 5'h04
`define DWU_WF_SIZE 5'h08
`define DWU_WF_XOFF 5'h0c
`define DWU_WF_YOFF 5'h10
`define DWU_WF_ZOOM 5'h14

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define DWU_MC_OCC_BIT 4
`define DWU_MC_RUN_BIT 8
`define DWU_MM_DEPTH_BIT 2
`define DWU_SIZE_H_LSB 16
`define DWU_ZOOM_Y_LSB 16
`define DWU_ST_DAC_BIT 12
`define DWU_ST_OVL_BIT 13
`define DWU_ST_GAP_LSB 16

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define DWU_ZOOM_UNITY 9'h100
`define DWU_ACTIVE_RST 12'h280
`define DWU_MEMMAP_RST 3'h4

////////////////////////////////////////////////////////////////////////////////
// Timing
`define DWU_PCLK_NS 100
`define DWU_MIN_GAP_NS 1000
`define DWU_MIN_GAP_CYC ((`DWU_MIN_GAP_NS + `DWU_PCLK_NS - 1) / `DWU_PCLK_NS)

`endif

//--- rtl/dwu_pkg.sv
package dwu_pkg;
    typedef logic [21:0] dwu_pix_addr_t;
    typedef logic [11:0] dwu_coord_t;
    typedef enum logic [1:0] {RS_IDLE, RS_ACTIVE, RS_BLANK} dwu_raster_state_t;
    typedef enum logic [3:0] {
        REG_NONE, REG_MASTER, REG_ACTIVE, REG_MEMMAP, REG_STATUS,
        REG_START, REG_PITCH, REG_SIZE, REG_XOFF, REG_YOFF, REG_ZOOM
    } dwu_reg_t;
endpackage

//--- rtl/dwu_mem_xlat.sv
`timescale 1ns/1ps
`include "dwu_cfg.svh"

module dwu_mem_xlat (
    input wire dwu_pkg::dwu_pix_addr_t pix_addr,
    input wire logic depth32,
    input wire logic [1:0] dev_sel,
    output logic bank,
    output logic [10:0] row,
    output logic [10:0] col,
    output logic [3:0] lanes
);
    import dwu_pkg::*;

    logic [20:0] word;
    logic [22:0] word_ext;
    logic [3:0] col_bits;
    logic [10:0] mask;

    // Square devices: row and column widths both follow the device size
    always_comb begin
        word = pix_addr[21:1];
        col_bits = 4'(4'h8 + {2'h0, dev_sel});
        mask = 11'(({11'h0, 1'b1} << col_bits) - 12'h001);
        col = word[10:0] & mask;
        row = 11'(word >> col_bits) & mask;
        // Largest device leaves no bank bit inside the word, so bank 0
        word_ext = {2'b00, word};
        bank = word_ext[5'({1'b0, col_bits} << 1)];
        // Narrow buffers exist only in the low half of each word
        if (!depth32 || !pix_addr[0]) begin
            lanes = 4'h3;
        end else begin
            lanes = 4'hc;
        end
    end
endmodule

//--- rtl/dwu_raster.sv
`timescale 1ns/1ps
`include "dwu_cfg.svh"

module dwu_raster #(
    parameter int BLANK_CYC = 160,
    parameter int ROWS = 480
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire dwu_pkg::dwu_coord_t active_pixels,
    output dwu_pkg::dwu_coord_t x,
    output dwu_pkg::dwu_coord_t y,
    output logic pix_active,
    output logic line_end,
    output logic frame_start
);
    import dwu_pkg::*;

    dwu_raster_state_t state_r;
    dwu_coord_t x_r, y_r;
    logic [11:0] blank_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= RS_IDLE;
            x_r <= 12'h000;
            y_r <= 12'h000;
            blank_r <= 12'h000;
        end else if (!run) begin
            state_r <= RS_IDLE;
        end else begin
            unique case (state_r)
                RS_IDLE: begin
                    state_r <= RS_ACTIVE;
                    x_r <= 12'h000;
                    y_r <= 12'h000;
                end
                RS_ACTIVE: begin
                    // Only the active width is programmed, row count is fixed
                    if (x_r >= active_pixels - 12'h001) begin
                        state_r <= RS_BLANK;
                        blank_r <= 12'h000;
                    end
                    x_r <= 12'(x_r + 12'h001);
                end
                RS_BLANK: begin
                    blank_r <= 12'(blank_r + 12'h001);
                    if (blank_r == 12'(BLANK_CYC - 1)) begin
                        state_r <= RS_ACTIVE;
                        x_r <= 12'h000;
                        y_r <= (y_r == 12'(ROWS - 1)) ? 12'h000 : 12'(y_r + 12'h001);
                    end
                end
            endcase
        end
    end

    assign x = x_r;
    assign y = y_r;
    assign pix_active = (state_r == RS_ACTIVE);
    assign line_end = (state_r == RS_BLANK) && (blank_r == 12'(BLANK_CYC - 1));
    assign frame_start = run && ((state_r == RS_IDLE) ||
        (line_end && (y_r == 12'(ROWS - 1))));
endmodule

//--- rtl/dwu_display_window_unit.sv
`timescale 1ns/1ps
`include "dwu_cfg.svh"

// Contract
// - Four windows, each independently enabled
// - Start address counts from buffer zero
// - Pitch sets reference frame width, pixels
// - Window size in 16-bit pixels
// - X offset from raster left edge
// - Y offset from raster top row
// - Register holds active pixels per line
// - Zoom only with DAC, scale 256/zoom
// - Overlap allowed with DAC and occlusion
// - Hardware enforces only left/right frame bounds
// - Translate to eight megabyte physical space
// - Depth 16 reaches only low pixel
// - Pseudocolour fills only low half; at depth 32 wr_pseudo is ignored and the whole word is written
// - 32-bit bus, two bank strobes
// - Four byte column strobes
// - Device select shapes physical address
module dwu_display_window_unit #(
    parameter int BLANK_CYC = 160,
    parameter int ROWS = 480,
    parameter int NWIN = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dac_present,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire dwu_pkg::dwu_pix_addr_t wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_pseudo,
    output logic [1:0] fb_ras_n,
    output logic [3:0] fb_cas_n,
    output logic [10:0] fb_row,
    output logic [10:0] fb_col,
    output logic fb_we_n,
    input wire logic [31:0] fb_data_in,
    output logic [31:0] fb_data_out,
    output logic fb_data_oe,
    output logic pix_valid,
    output logic [15:0] pix_data,
    output logic [1:0] pix_window
);
    import dwu_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register decode

    function automatic dwu_reg_t reg_decode(input logic [11:0] a);
        reg_decode = REG_NONE;
        if (a[11:8] == 4'h0 && a[1:0] == 2'b00) begin
            if (a[`DWU_WIN_BASE_BIT]) begin
                unique case (a[4:0])
                    `DWU_WF_START: reg_decode = REG_START;
                    `DWU_WF_PITCH: reg_decode = REG_PITCH;
                    `DWU_WF_SIZE: reg_decode = REG_SIZE;
                    `DWU_WF_XOFF: reg_decode = REG_XOFF;
                    `DWU_WF_YOFF: reg_decode = REG_YOFF;
                    `DWU_WF_ZOOM: reg_decode = REG_ZOOM;
                    default: reg_decode = REG_NONE;
                endcase
            end else begin
                unique case (a[7:0])
                    `DWU_OFF_MASTER: reg_decode = REG_MASTER;
                    `DWU_OFF_ACTIVE: reg_decode = REG_ACTIVE;
                    `DWU_OFF_MEMMAP: reg_decode = REG_MEMMAP;
                    `DWU_OFF_STATUS: reg_decode = REG_STATUS;
                    default: reg_decode = REG_NONE;
                endcase
            end
        end
    endfunction

    // Zero or out-of-range zoom falls back to unity; no DAC means unity too
    function automatic logic [8:0] eff_zoom(input logic [8:0] z, input logic dac);
        if (!dac || z == 9'h000 || z > `DWU_ZOOM_UNITY) begin
            eff_zoom = `DWU_ZOOM_UNITY;
        end else begin
            eff_zoom = z;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [3:0] win_en_r;
    logic occ_r, run_r, depth32_r, ovl_r;
    logic [1:0] dev_sel_r;
    dwu_coord_t active_r;
    dwu_pix_addr_t start_r [NWIN];
    dwu_coord_t pitch_r [NWIN];
    dwu_coord_t width_r [NWIN];
    dwu_coord_t height_r [NWIN];
    dwu_coord_t xoff_r [NWIN];
    dwu_coord_t yoff_r [NWIN];
    logic [8:0] zx_r [NWIN];
    logic [8:0] zy_r [NWIN];
    logic dac_s1_r, dac_s2_r;
    logic [31:0] prdata_r;

    dwu_reg_t rd_kind, wr_kind;
    logic [1:0] rd_win, wr_win;
    logic wr_en;
    logic ovl_now;
    dwu_coord_t rx, ry;
    logic raster_act, line_end, frame_start;

    assign rd_kind = reg_decode(paddr);
    assign wr_kind = reg_decode(paddr);
    assign rd_win = paddr[6:5];
    assign wr_win = paddr[6:5];
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (wr_kind == REG_NONE);
    assign prdata = prdata_r;

    // DAC presence is a board level, caught through two stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_s1_r <= 1'b0;
            dac_s2_r <= 1'b0;
        end else begin
            dac_s1_r <= dac_present;
            dac_s2_r <= dac_s1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_en_r <= 4'h0;
            occ_r <= 1'b0;
            run_r <= 1'b0;
            active_r <= `DWU_ACTIVE_RST;
            {dev_sel_r, depth32_r} <= `DWU_MEMMAP_RST;
        end else if (wr_en) begin
            unique case (wr_kind)
                REG_MASTER: begin
                    win_en_r <= pwdata[3:0];
                    occ_r <= pwdata[`DWU_MC_OCC_BIT];
                    run_r <= pwdata[`DWU_MC_RUN_BIT];
                end
                REG_ACTIVE: active_r <= pwdata[11:0];
                REG_MEMMAP: begin
                    depth32_r <= pwdata[`DWU_MM_DEPTH_BIT];
                    dev_sel_r <= pwdata[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NWIN; i++) begin
                start_r[i] <= 22'h000000;
                pitch_r[i] <= 12'h000;
                width_r[i] <= 12'h000;
                height_r[i] <= 12'h000;
                xoff_r[i] <= 12'h000;
                yoff_r[i] <= 12'h000;
                zx_r[i] <= `DWU_ZOOM_UNITY;
                zy_r[i] <= `DWU_ZOOM_UNITY;
            end
        end else if (wr_en) begin
            unique case (wr_kind)
                REG_START: start_r[wr_win] <= pwdata[21:0];
                REG_PITCH: pitch_r[wr_win] <= pwdata[11:0];
                REG_SIZE: begin
                    width_r[wr_win] <= pwdata[11:0];
                    height_r[wr_win] <= pwdata[`DWU_SIZE_H_LSB +: 12];
                end
                REG_XOFF: xoff_r[wr_win] <= pwdata[11:0];
                REG_YOFF: yoff_r[wr_win] <= pwdata[11:0];
                REG_ZOOM: begin
                    zx_r[wr_win] <= pwdata[8:0];
                    zy_r[wr_win] <= pwdata[`DWU_ZOOM_Y_LSB +: 9];
                end
                default: begin
                end
            endcase
        end
    end

    // Overlap flag: hardware set beats a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovl_r <= 1'b0;
        end else if (ovl_now) begin
            ovl_r <= 1'b1;
        end else if (wr_en && wr_kind == REG_STATUS && pwdata[`DWU_ST_OVL_BIT]) begin
            ovl_r <= 1'b0;
        end
    end

    // Read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= 32'h00000000;
            unique case (rd_kind)
                REG_MASTER: prdata_r <= {23'h000000, run_r, 3'h0, occ_r, win_en_r};
                REG_ACTIVE: prdata_r <= {20'h00000, active_r};
                REG_MEMMAP: prdata_r <= {29'h00000000, depth32_r, dev_sel_r};
                REG_STATUS: prdata_r <= {8'h00, 8'(`DWU_MIN_GAP_CYC), 2'h0, ovl_r,
                    dac_s2_r, ry};
                REG_START: prdata_r <= {10'h000, start_r[rd_win]};
                REG_PITCH: prdata_r <= {20'h00000, pitch_r[rd_win]};
                REG_SIZE: prdata_r <= {4'h0, height_r[rd_win], 4'h0, width_r[rd_win]};
                REG_XOFF: prdata_r <= {20'h00000, xoff_r[rd_win]};
                REG_YOFF: prdata_r <= {20'h00000, yoff_r[rd_win]};
                REG_ZOOM: prdata_r <= {7'h00, zy_r[rd_win], 7'h00, zx_r[rd_win]};
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Raster and window walkers

    dwu_raster #(.BLANK_CYC(BLANK_CYC), .ROWS(ROWS)) u_raster (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_r),
        .active_pixels(active_r),
        .x(rx),
        .y(ry),
        .pix_active(raster_act),
        .line_end(line_end),
        .frame_start(frame_start)
    );

    logic [NWIN-1:0] hit;
    dwu_pix_addr_t fetch_addr [NWIN];

    generate
        for (genvar g = 0; g < NWIN; g++) begin : g_win
            logic [19:0] hacc_r;
            logic [7:0] yfrac_r;
            dwu_coord_t rows_r;
            dwu_pix_addr_t row_base_r;
            logic vis_row;
            logic [9:0] ysum;

            assign vis_row = (ry >= yoff_r[g]) && (rows_r < height_r[g]);
            assign ysum = {2'b00, yfrac_r} + {1'b0, eff_zoom(zy_r[g], dac_s2_r)};
            // Right edge of the reference frame is the pitch; top and bottom are not
            assign hit[g] = win_en_r[g] && raster_act && vis_row &&
                (rx >= xoff_r[g]) && (hacc_r[19:8] < width_r[g]) &&
                (hacc_r[19:8] < pitch_r[g]);
            assign fetch_addr[g] = 22'(row_base_r + {10'h000, hacc_r[19:8]});

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    hacc_r <= 20'h00000;
                    yfrac_r <= 8'h00;
                    rows_r <= 12'h000;
                    row_base_r <= 22'h000000;
                end else if (frame_start) begin
                    hacc_r <= 20'h00000;
                    yfrac_r <= 8'h00;
                    rows_r <= 12'h000;
                    row_base_r <= start_r[g];
                end else if (line_end) begin
                    hacc_r <= 20'h00000;
                    if (vis_row) begin
                        yfrac_r <= ysum[7:0];
                        if (ysum[9:8] != 2'b00) begin
                            row_base_r <= 22'(row_base_r + {10'h000, pitch_r[g]});
                            rows_r <= 12'(rows_r + 12'h001);
                        end
                    end
                end else if (hit[g]) begin
                    hacc_r <= 20'(hacc_r + {11'h000, eff_zoom(zx_r[g], dac_s2_r)});
                end
            end
        end
    endgenerate

    // Lowest window on top; stacking is legal only with DAC and occlusion
    logic [1:0] sel_win;
    logic any_hit;
    always_comb begin
        sel_win = 2'h0;
        any_hit = |hit;
        for (int i = NWIN - 1; i >= 0; i--) begin
            if (hit[i]) begin
                sel_win = 2'(i);
            end
        end
    end
    assign ovl_now = ((hit & (hit - 4'h1)) != 4'h0) && !(occ_r && dac_s2_r);

    ////////////////////////////////////////////////////////////////////////////
    // Frame buffer port

    logic f_bank, w_bank;
    logic [10:0] f_row, f_col, w_row, w_col;
    logic [3:0] f_lanes, w_lanes;

    dwu_mem_xlat u_fetch_xlat (
        .pix_addr(fetch_addr[sel_win]),
        .depth32(depth32_r),
        .dev_sel(dev_sel_r),
        .bank(f_bank),
        .row(f_row),
        .col(f_col),
        .lanes(f_lanes)
    );

    dwu_mem_xlat u_write_xlat (
        .pix_addr(wr_addr),
        .depth32(depth32_r),
        .dev_sel(dev_sel_r),
        .bank(w_bank),
        .row(w_row),
        .col(w_col),
        .lanes(w_lanes)
    );

    // Display fetch never waits; writes take the idle cycles
    assign wr_ready = !any_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_ras_n <= 2'b11;
            fb_cas_n <= 4'hf;
            fb_row <= 11'h000;
            fb_col <= 11'h000;
            fb_we_n <= 1'b1;
            fb_data_out <= 32'h00000000;
            fb_data_oe <= 1'b0;
        end else if (any_hit) begin
            fb_ras_n <= f_bank ? 2'b01 : 2'b10;
            fb_cas_n <= ~f_lanes;
            fb_row <= f_row;
            fb_col <= f_col;
            fb_we_n <= 1'b1;
            fb_data_oe <= 1'b0;
        end else if (wr_valid) begin
            fb_ras_n <= w_bank ? 2'b01 : 2'b10;
            fb_row <= w_row;
            fb_col <= w_col;
            fb_we_n <= 1'b0;
            fb_data_oe <= 1'b1;
            if (!depth32_r) begin
                // Narrow mode: only the low half carries data
                fb_cas_n <= 4'hc;
                fb_data_out <= wr_pseudo ? {24'h000000, wr_data[7:0]}
                    : {16'h0000, wr_data[15:0]};
            end else begin
                fb_cas_n <= 4'h0;
                fb_data_out <= wr_data;
            end
        end else begin
            fb_ras_n <= 2'b11;
            fb_cas_n <= 4'hf;
            fb_we_n <= 1'b1;
            fb_data_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pixel return

    logic [31:0] rd_s1_r, rd_s2_r;
    logic [3:0] pv_r;
    logic [2:0] hi_r;
    logic [1:0] pw_r [4];

    // Read bus comes from the pins, so it passes two stages first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_s1_r <= 32'h00000000;
            rd_s2_r <= 32'h00000000;
            pv_r <= 4'h0;
            hi_r <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                pw_r[i] <= 2'h0;
            end
            pix_data <= 16'h0000;
        end else begin
            rd_s1_r <= fb_data_in;
            rd_s2_r <= rd_s1_r;
            // Valid waits one more stage so it stands with its data
            pv_r <= {pv_r[2:0], any_hit};
            hi_r <= {hi_r[1:0], f_lanes[3]};
            pw_r[0] <= sel_win;
            pw_r[1] <= pw_r[0];
            pw_r[2] <= pw_r[1];
            pw_r[3] <= pw_r[2];
            pix_data <= hi_r[2] ? rd_s2_r[31:16] : rd_s2_r[15:0];
        end
    end

    assign pix_valid = pv_r[3];
    assign pix_window = pw_r[3];
endmodule

//--- test/dwu_asserts.sv
`timescale 1ns/1ps
module dwu_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic wr_pseudo,
    input wire logic [1:0] fb_ras_n,
    input wire logic [3:0] fb_cas_n,
    input wire logic fb_we_n,
    input wire logic [31:0] fb_data_out,
    input wire logic pix_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic fetch;
    assign fetch = fb_ras_n != 2'b11 && fb_we_n;
    ////////////////////////////////////////////////////////////
    property p_bank_one; fb_ras_n != 2'b00; endproperty
    a_bank_one: assert property (p_bank_one) else $error("both banks");
    property p_idle_lanes; fb_ras_n == 2'b11 |-> fb_cas_n == 4'hf; endproperty
    a_idle_lanes: assert property (p_idle_lanes) else $error("idle lanes");
    property p_read_lanes; fetch |-> fb_cas_n inside {4'h3, 4'hc}; endproperty
    a_read_lanes: assert property (p_read_lanes) else $error("read lanes");
    property p_write_lanes; !fb_we_n |-> fb_ras_n != 2'b11 && fb_cas_n inside {4'h0, 4'hc};
    endproperty
    a_write_lanes: assert property (p_write_lanes) else $error("write lanes");
    property p_narrow; !fb_we_n && fb_cas_n == 4'hc |-> fb_data_out[31:16] == 16'h0
        && (!$past(wr_pseudo) || fb_data_out[15:8] == 8'h0); endproperty
    a_narrow: assert property (p_narrow) else $error("narrow data");
    // Pixel lags its strobe by three cycles: the two bus sync stages plus the pixel output register
    property p_fetch_pix; fetch |-> ##3 pix_valid; endproperty
    a_fetch_pix: assert property (p_fetch_pix) else $error("pixel late");
    property p_pix_cause; pix_valid |-> $past(fetch, 3); endproperty
    a_pix_cause: assert property (p_pix_cause) else $error("stray pixel");
    property p_wr_cause; !fb_we_n |-> $past(wr_valid && wr_ready); endproperty
    a_wr_cause: assert property (p_wr_cause) else $error("stray write");
    c_wide: cover property (!fb_we_n && fb_cas_n == 4'h0);
    c_low: cover property (!fb_we_n && fb_cas_n == 4'hc);
    c_pix: cover property (pix_valid);
endmodule
bind dwu_display_window_unit dwu_asserts u_chk (.pclk, .presetn, .wr_valid, .wr_ready,
    .wr_pseudo, .fb_ras_n, .fb_cas_n, .fb_we_n, .fb_data_out, .pix_valid);

//--- test/dwu_fb_model.sv
`timescale 1ns/1ps
module dwu_fb_model (
    input wire logic pclk,
    input wire logic [1:0] fb_ras_n,
    input wire logic [3:0] fb_cas_n,
    input wire logic [10:0] fb_row,
    input wire logic [10:0] fb_col,
    input wire logic fb_we_n,
    input wire logic [31:0] fb_data_out,
    output logic [31:0] fb_data_in
);
    logic [31:0] mem [logic [22:0]];
    logic [31:0] noise = 32'h1234abcd;
    logic [22:0] key;
    // Strobe picks one of two 32-bit banks
    assign key = {fb_ras_n == 2'b01, fb_row, fb_col};
    always @(posedge pclk) begin
        noise <= {noise[30:0], noise[31] ^ noise[21] ^ noise[1] ^ noise[0]};
        if (fb_ras_n != 2'b11 && !fb_we_n) begin
            if (!mem.exists(key)) mem[key] = 32'h0;
            for (int i = 0; i < 4; i++) begin
                if (!fb_cas_n[i]) mem[key][8*i +: 8] = fb_data_out[8*i +: 8];
            end
        end
    end
    // Idle bus shows noise, never the last word
    always @* begin
        if (fb_ras_n != 2'b11 && fb_we_n) begin
            fb_data_in = mem.exists(key) ? mem[key] : {~key[15:0], key[15:0]};
        end else begin
            fb_data_in = noise;
        end
    end
endmodule

//--- test/dwu_display_window_unit_tb_top.sv
`timescale 1ns/1ps
module dwu_display_window_unit_tb_top;
    import dwu_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, b;
    logic wr_valid, wr_ready, wr_pseudo, fb_we_n, fb_data_oe, pix_valid, dac;
    logic [11:0] paddr, a;
    logic [31:0] pwdata, prdata, fb_data_in, fb_data_out, wr_data, q, v;
    logic [31:0] seed = 32'h000131c8;
    logic [1:0] fb_ras_n, pix_window;
    logic [3:0] fb_cas_n;
    logic [10:0] fb_row, fb_col;
    logic [15:0] pix_data;
    logic [20:0] w;
    dwu_pix_addr_t wr_addr, s;
    dwu_pix_addr_t fq[$];
    logic [15:0] dq[$];
    logic [31:0] wmask[6] = '{32'h3fffff, 32'hfff, 32'hfff0fff, 32'hfff, 32'hfff, 32'h1ff01ff};
    logic [11:0] bad[4] = '{12'h010, 12'h0fc, 12'h102, 12'h801};
    int n_errors = 0;
    int check_count = 0;
    int cb;
    ////////////////////////////////////////////////////////////
    dwu_display_window_unit #(.BLANK_CYC(4), .ROWS(4)) u_dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dac_present(dac),
        .wr_valid, .wr_ready, .wr_addr, .wr_data, .wr_pseudo, .fb_ras_n, .fb_cas_n, .fb_row,
        .fb_col, .fb_we_n, .fb_data_in, .fb_data_out, .fb_data_oe, .pix_valid, .pix_data,
        .pix_window);
    dwu_fb_model u_fb (.pclk, .fb_ras_n, .fb_cas_n, .fb_row, .fb_col, .fb_we_n,
        .fb_data_out, .fb_data_in);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] ad, input logic [31:0] ex, input string nm);
        apb(1'b0, ad, 32'h0);
        chk(nm, ex, q);
    endtask
    task wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Fetch monitor rebuilds pixel address from bank, row, column, lane
    always @(posedge pclk) begin
        if (fb_ras_n != 2'b11 && fb_we_n) begin
            fq.push_back({fb_ras_n == 2'b01, fb_row[9:0], fb_col[9:0], fb_cas_n == 4'h3});
            dq.push_back(fb_cas_n == 4'h3 ? fb_data_in[31:16] : fb_data_in[15:0]);
        end
        if (pix_valid) begin
            chk("pixel window", 32'h1, 32'(pix_window));
            chk("pixel data", 32'(dq.pop_front()), 32'(pix_data));
        end
    end
    // About forty times the expected run
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite, wr_valid, wr_pseudo, dac} = '0;
        {paddr, pwdata, wr_addr, wr_data} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, 32'h0, "master");
        rd(12'h004, 32'h280, "active");
        rd(12'h008, 32'h2, "memmap");
        rd(12'h094, 32'h01000100, "zoom");
        apb(1'b0, 12'h00c, 32'h0);
        chk("gap", 32'ha, 32'(q[23:16]));
        chk("dac", 32'h0, 32'(q[12]));
        foreach (bad[i]) begin
            apb(1'b1, bad[i], 32'h0);
            chk("slverr", 32'h1, 32'(e));
        end
        $display("test reset done");
        for (int i = 0; i < 25; i++) begin
            a = i > 23 ? 12'h000 : 12'h080 + 12'(i / 6 * 32 + i % 6 * 4);
            v = rnd() & (i > 23 ? 32'h1f : wmask[i % 6]);
            apb(1'b1, a, v);
            rd(a, v, "reg");
        end
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h008, 32'(i));
            cb = 8 + i % 4;
            @(posedge pclk);
            wr_valid <= 1'b1;
            wr_addr <= 22'(rnd());
            wr_data <= rnd();
            wr_pseudo <= seed[3];
            do @(posedge pclk); while (wr_ready !== 1'b1);
            wr_valid <= 1'b0;
            #1;
            w = wr_addr[21:1];
            b = 1'(w >> (2 * cb));
            chk("ras", 32'({!b, b}), 32'(fb_ras_n));
            chk("col", 32'(w & ((21'h1 << cb) - 1)), 32'(fb_col));
            chk("row", 32'((w >> cb) & ((21'h1 << cb) - 1)), 32'(fb_row));
            chk("cas", i < 4 ? 32'hc : 32'h0, 32'(fb_cas_n));
            v = i > 3 ? wr_data : wr_pseudo ? 32'(wr_data[7:0]) : 32'(wr_data[15:0]);
            chk("wdata", v, fb_data_out);
            chk("oe", 32'h1, 32'(fb_data_oe));
        end
        $display("test writes done");
        apb(1'b1, 12'h004, 32'h8);
        apb(1'b1, 12'h008, 32'h6);
        s = 22'(rnd()) & 22'h0fffff;
        apb(1'b1, 12'h0a0, 32'(s));
        apb(1'b1, 12'h0a4, 32'h10);
        apb(1'b1, 12'h0a8, 32'h00020004);
        apb(1'b1, 12'h0ac, 32'h2);
        apb(1'b1, 12'h0b0, 32'h1);
        apb(1'b1, 12'h000, 32'h100);
        repeat (100) @(posedge pclk);
        chk("idle", 32'h0, 32'(fq.size()));
        apb(1'b1, 12'h000, 32'h0);
        fq.delete();
        apb(1'b1, 12'h000, 32'h102);
        repeat (100) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            chk("fetch", 32'(s + 22'(i / 4 * 16 + i % 4)), 32'(fq[i]));
        end
        $display("test fetch done");
        dac <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, 12'h00c, 32'h0);
        chk("dac", 32'h1, 32'(q[12]));
        $display("test dac done");
        wrap_up();
    end
endmodule
